// >>> cbes_pkg.sv
package cbes_pkg;
    // output count and settle timing
    localparam int NUM_OUT = 3;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_TIME_NS = 1000;
    // least time, rounded up to whole cycles
    localparam int SETTLE_CYC =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
    localparam int SYNC_STAGES = 2;
    // divide ratio of the two divided outputs; must be even
    localparam int DIV_RATIO_DEF = 4;
    // bit positions of the synchronised pin vector
    localparam int PIN_IN = 0;
    localparam int PIN_EN = 1;
    localparam int PIN_EN_FLOAT = 2;
    localparam int PIN_MODE = 3;
    localparam int PIN_MODE_FLOAT = 6;
    localparam int PIN_W = 9;
    // output lanes: lane 0 undivided, lanes 1 and 2 divided
    localparam int LANE_UNDIV = 0;
    // reset values of the driver outputs
    localparam logic [2:0] Y_TRUE_RST = 3'h0;
    localparam logic [2:0] Y_COMP_RST = 3'h7;
    localparam logic [2:0] OE_B_RST = 3'h7;
    localparam logic [2:0] ALL_HIGH = 3'h7;
    localparam logic [2:0] ALL_LOW = 3'h0;

    // gray coded along off, settle, low, run
    typedef enum logic [1:0]
    {
        ST_OFF = 2'h0,
        ST_SETTLE = 2'h1,
        ST_LOW = 2'h3,
        ST_RUN = 2'h2
    } cbes_state_type;
endpackage

// >>> cbes_div_if.sv
interface cbes_div_if #(parameter int CNT_W = 2);
    logic clear;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic out;

    modport ctrl
    (
        output clear,
        output tick,
        input cnt,
        input out
    );
    modport div
    (
        input clear,
        input tick,
        output cnt,
        output out
    );
endinterface

// >>> cbes_sync.sv
module cbes_sync
    import cbes_pkg::*;
#(
    parameter int W = PIN_W
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    generate
        if (W < 1)
        begin : g_chk
            $error("cbes_sync: width must be at least one");
        end
    endgenerate

    // two stages; only the second stage reads meta
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> cbes_div.sv
module cbes_div
    import cbes_pkg::*;
#(
    parameter int RATIO = DIV_RATIO_DEF,
    parameter int CNT_W = 2
)
(
    input wire logic clk,
    input wire logic rst_b,
    cbes_div_if.div port
);
    localparam logic [CNT_W-1:0] last_c = CNT_W'(RATIO / 2 - 1);
    wire logic at_last;
    wire logic [CNT_W-1:0] cnt_inc;

    generate
        if (RATIO < 2 || (RATIO % 2) != 0 || (1 << CNT_W) < RATIO / 2)
        begin : g_chk
            $error("cbes_div: ratio must be even, at least two, and fit");
        end
    endgenerate

    assign at_last = (port.cnt == last_c);
    assign cnt_inc = port.cnt + CNT_W'(1);

    // only the global clear resets the count, never a lane enable
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port.cnt <= '0;
            port.out <= 1'b0;
        end
        else if (port.clear)
        begin
            port.cnt <= '0;
            port.out <= 1'b0;
        end
        else if (port.tick)
        begin
            port.cnt <= at_last ? '0 : cnt_inc;
            port.out <= at_last ? ~port.out : port.out;
        end
    end
endmodule

// >>> cbes_top.sv
module cbes_top
    import cbes_pkg::*;
#(
    parameter int DIV_RATIO = DIV_RATIO_DEF
)
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic IN_CLK,
    input wire logic EN,
    input wire logic EN_FLOAT,
    input wire logic MODE_SELECT_BIT0,
    input wire logic MODE_SELECT_BIT1,
    input wire logic MODE_SELECT_BIT2,
    input wire logic MODE_SELECT_BIT0_FLOAT,
    input wire logic MODE_SELECT_BIT1_FLOAT,
    input wire logic MODE_SELECT_BIT2_FLOAT,
    output logic [NUM_OUT-1:0] Y_TRUE,
    output logic [NUM_OUT-1:0] Y_COMP,
    output logic [NUM_OUT-1:0] Y_OE_B
);
    localparam int DIV_CNT_W = $clog2(DIV_RATIO / 2 + 1);
    localparam int settle_len_c = SETTLE_CYC;
    localparam logic [SETTLE_W-1:0] settle_last = SETTLE_W'(SETTLE_CYC - 1);

    generate
        if (NUM_OUT != 3 || DIV_RATIO < 2 || (DIV_RATIO % 2) != 0)
        begin : g_chk
            $error("cbes_top: three lanes and an even ratio are needed");
        end
    endgenerate

    wire logic [PIN_W-1:0] pins_raw;
    wire logic [PIN_W-1:0] pins_s;
    wire logic in_s;
    wire logic en_res;
    wire logic [2:0] mode_res;
    wire logic in_rise;
    wire logic settle_done;
    logic in_prev;
    logic en_latch;
    logic [2:0] mode_latch;
    logic armed;
    logic [SETTLE_W-1:0] settle_cnt;
    cbes_state_type state;
    cbes_state_type next_state;
    logic [NUM_OUT-1:0] next_y_true;
    logic [NUM_OUT-1:0] next_oe_b;

    cbes_div_if #(.CNT_W(DIV_CNT_W)) div_bus();

    // every pin, the input clock among them, crosses two flops first
    assign pins_raw = {MODE_SELECT_BIT2_FLOAT, MODE_SELECT_BIT1_FLOAT,
        MODE_SELECT_BIT0_FLOAT, MODE_SELECT_BIT2, MODE_SELECT_BIT1,
        MODE_SELECT_BIT0, EN_FLOAT, EN, IN_CLK};

    cbes_sync #(.W(PIN_W)) u_sync
    (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .d(pins_raw),
        .q(pins_s)
    );

    // pad pull-ups: a floating pin resolves high
    assign in_s = pins_s[PIN_IN];
    assign en_res = pins_s[PIN_EN] | pins_s[PIN_EN_FLOAT];
    assign mode_res = pins_s[PIN_MODE +: 3]
        | pins_s[PIN_MODE_FLOAT +: 3];
    assign in_rise = in_s & ~in_prev;
    assign settle_done = (settle_cnt == settle_last);

    // divider runs only once outputs are resynchronised to the clock
    assign div_bus.clear = ~en_latch;
    assign div_bus.tick = in_rise & (state == ST_RUN);

    cbes_div #(.RATIO(DIV_RATIO), .CNT_W(DIV_CNT_W)) u_div
    (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .port(div_bus.div)
    );

    // edge detect on the synchronised clock
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            in_prev <= 1'b0;
        else
            in_prev <= in_s;
    end

    // controls latch on the clock rising edge; a stopped clock holds them
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            en_latch <= 1'b0;
        else if (in_rise)
            en_latch <= en_res;
    end

    // mode selects switched off while disabled
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            mode_latch <= 3'h0;
        else if (!en_latch)
            mode_latch <= 3'h0;
        else if (in_rise)
            mode_latch <= mode_res;
    end

    // undivided lane waits for a rising edge after its own enable
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            armed <= 1'b0;
        else if (!en_latch || !mode_latch[LANE_UNDIV])
            armed <= 1'b0;
        else if (in_rise && state == ST_RUN)
            armed <= 1'b1;
    end

    // settle counter, cleared outside the settle phase
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            settle_cnt <= '0;
        else if (state == ST_SETTLE && en_latch)
            settle_cnt <= settle_cnt + SETTLE_W'(1);
        else
            settle_cnt <= '0;
    end

    // sequencing of enable, settle, low hold and run
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_OFF:
                if (en_latch)
                    next_state = ST_SETTLE;
            ST_SETTLE:
                if (settle_done)
                    next_state = ST_LOW;
            ST_LOW:
                if (in_rise)
                    next_state = ST_RUN;
            ST_RUN:
                next_state = ST_RUN;
        endcase
        if (!en_latch)
            next_state = ST_OFF;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // driver levels and enables per phase
    always_comb
    begin
        next_y_true = Y_TRUE;
        next_oe_b = OE_B_RST;
        unique case (state)
            ST_OFF:
            begin
                next_y_true = ALL_LOW;
                next_oe_b = OE_B_RST;
            end
            ST_SETTLE:
            begin
                next_y_true = ALL_HIGH;
                next_oe_b = ALL_LOW;
            end
            ST_LOW:
            begin
                next_y_true = ALL_LOW;
                next_oe_b = ALL_LOW;
            end
            ST_RUN:
            begin
                // level before the first edge is left as it was
                next_y_true[0] = armed ? in_s : Y_TRUE[0];
                next_y_true[1] = div_bus.out;
                next_y_true[2] = div_bus.out;
                next_oe_b = ~mode_latch;
            end
        endcase
        if (!en_latch)
            next_oe_b = OE_B_RST;
    end

    // all outputs registered; complement derived from the same next value
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            Y_TRUE <= Y_TRUE_RST;
            Y_COMP <= Y_COMP_RST;
            Y_OE_B <= OE_B_RST;
        end
        else
        begin
            Y_TRUE <= next_y_true;
            Y_COMP <= ~next_y_true;
            Y_OE_B <= next_oe_b;
        end
    end

    disabled_hiz_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        !en_latch |=> (Y_OE_B == OE_B_RST))
        else $error("drivers not high impedance while disabled");

    mode_ignored_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        !en_latch |=> (mode_latch == 3'h0))
        else $error("mode selects active while disabled");

    state_reset_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        !en_latch ##1 !en_latch |-> (state == ST_OFF)
            && (div_bus.cnt == '0) && !armed)
        else $error("internal state not held reset while disabled");

    settle_high_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B || !en_latch)
        $rose(state == ST_SETTLE) |-> ##settle_len_c (state == ST_LOW))
        else $error("settle interval has the wrong length");

    settle_drive_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        (state == ST_SETTLE) && en_latch |=>
            (Y_TRUE == ALL_HIGH) && (Y_OE_B == ALL_LOW))
        else $error("true outputs not driven high while settling");

    settle_low_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        (state == ST_SETTLE) ##1 (state == ST_LOW) && en_latch |=>
            (Y_TRUE == ALL_LOW))
        else $error("outputs not low after settling");

    run_aligned_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        $rose(state == ST_RUN) |-> $past(in_rise)
            && ($past(state) == ST_LOW))
        else $error("run started off an input clock edge");

    comp_inverse_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        Y_COMP == ~Y_TRUE)
        else $error("complement is not the inverse of true output");

    undiv_follow_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        (state == ST_RUN) && armed && en_latch
            && mode_latch[LANE_UNDIV] ##1 en_latch |->
            (Y_TRUE[0] == $past(in_s)) && !Y_OE_B[0])
        else $error("undivided lane does not follow the input clock");

    div_shown_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        (state == ST_RUN) && en_latch && $rose(mode_latch[1]) |=>
            (Y_TRUE[1] == $past(div_bus.out)) && !Y_OE_B[1])
        else $error("divided lane does not show the shared divider");

    div_kept_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        en_latch && !div_bus.tick |=> $stable(div_bus.cnt))
        else $error("divider count changed without a tick");

    latch_edge_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        !in_rise && en_latch |=> $stable(en_latch) && $stable(mode_latch))
        else $error("controls changed away from an input clock edge");

    float_high_a: assert property (
        @(posedge CLK_SYS) disable iff (!RST_B)
        pins_s[PIN_EN_FLOAT] && in_rise |=> en_latch)
        else $error("floating enable not read as high");
endmodule

// >>> tb_top.sv
module tb_top
    import cbes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys;
    logic rst_b;
    logic in_clk = 1'b0;
    logic en;
    logic en_float;
    logic [2:0] mode;
    logic [2:0] mode_float;
    logic [NUM_OUT-1:0] y_true;
    logic [NUM_OUT-1:0] y_comp;
    logic [NUM_OUT-1:0] y_oe_b;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 29926;
    int in_cnt = 0;
    logic [2:0] pin_h = 3'h0;
    logic [4:0] notes[$];
    logic [4:0] nt;
    logic [2:0] hist[16];

    cbes_top u_cbes_top
    (
        .CLK_SYS(clk_sys),
        .RST_B(rst_b),
        .IN_CLK(in_clk),
        .EN(en),
        .EN_FLOAT(en_float),
        .MODE_SELECT_BIT0(mode[0]),
        .MODE_SELECT_BIT1(mode[1]),
        .MODE_SELECT_BIT2(mode[2]),
        .MODE_SELECT_BIT0_FLOAT(mode_float[0]),
        .MODE_SELECT_BIT1_FLOAT(mode_float[1]),
        .MODE_SELECT_BIT2_FLOAT(mode_float[2]),
        .Y_TRUE(y_true),
        .Y_COMP(y_comp),
        .Y_OE_B(y_oe_b)
    );

    // system clock, 50 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // input clock at one eighth of the system rate, slow enough for the sync
    always @(posedge clk_sys)
    begin
        in_cnt <= (in_cnt + 1) % 8;
        in_clk <= (in_cnt < 4);
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(string what, logic [2:0] seen, logic [2:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // outputs are settled at the falling edge; notes pushed at the rising
    // edge before it describe that cycle, so there is no race
    always @(negedge clk_sys)
    begin
        if (notes.size() > 0)
            check("y_comp", y_comp, ~y_true);
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            case (nt[4:3])
                2'h0:
                begin
                    check("y_true", y_true, nt[2:0]);
                    check("y_comp_note", y_comp, ~nt[2:0]);
                end
                2'h1: check("y_oe_b", y_oe_b, nt[2:0]);
                2'h2: check("lane_period", y_true,
                    {~hist[15][2:1], ~hist[3][0]});
                default: check("lane0_pin", {2'h0, y_true[0]},
                    nt[2:0]);
            endcase
        end
        for (int i = 15; i > 0; i--)
            hist[i] = hist[i-1];
        hist[0] = y_true;
    end

    // one system cycle; pin history tracks the three-edge input latency
    task automatic step();
        @(posedge clk_sys);
        pin_h = {pin_h[1:0], in_clk};
    endtask

    task automatic note(logic [1:0] sel, logic [2:0] v);
        notes.push_back({sel, v});
    endtask

    task automatic wait_oe(logic [2:0] v);
        int i;
        i = 0;
        while (y_oe_b !== v && i < 60)
        begin
            step();
            i++;
        end
        if (i == 60)
        begin
            n_errors++;
            $display("MISMATCH wait y_oe_b expected %h seen %h", v, y_oe_b);
            give_verdict();
        end
    endtask

    // disabled: random selects must change nothing
    task automatic idle_check(int n);
        repeat (n)
        begin
            mode <= 3'($random(seed));
            note(2'h0, Y_TRUE_RST);
            note(2'h1, OE_B_RST);
            step();
        end
    endtask

    // settle window: all true outputs high, then low for one known cycle
    task automatic enable_run();
        wait_oe(3'h0);
        for (int i = 0; i < SETTLE_CYC; i++)
        begin
            note(2'h0, (i < SETTLE_CYC - 1) ? ALL_HIGH : ALL_LOW);
            note(2'h1, 3'h0);
            step();
        end
        // long enough for run entry, arming and one full divided period
        repeat (60) step();
    endtask

    task automatic run_check(int n, logic chk_oe, logic [2:0] oe);
        repeat (n)
        begin
            note(2'h2, 3'h0);
            note(2'h3, {2'h0, pin_h[2]});
            if (chk_oe)
                note(2'h1, oe);
            step();
        end
    endtask

    initial
    begin
        rst_b = 1'b0;
        en = 1'b0;
        en_float = 1'b0;
        mode = 3'h0;
        mode_float = 3'h0;
        repeat (10) step();
        rst_b <= 1'b1;
        step();
        idle_check(30);
        en <= 1'b1;
        mode <= 3'h7;
        enable_run();
        run_check(64, 1'b1, 3'h0);
        // drop the divided lanes mid-run; divider phase must not jump
        mode <= 3'h1;
        run_check(12, 1'b0, 3'h0);
        run_check(28, 1'b1, 3'h6);
        mode <= 3'h7;
        run_check(12, 1'b0, 3'h0);
        run_check(28, 1'b1, 3'h0);
        // lane 0 off then on: it must re-arm at a fresh input clock rise
        mode <= 3'h6;
        repeat (12) step();
        repeat (16)
        begin
            note(2'h1, 3'h1);
            step();
        end
        mode <= 3'h7;
        // time for the latch, the re-arm and a refilled lane history
        repeat (32) step();
        run_check(16, 1'b1, 3'h0);
        en <= 1'b0;
        wait_oe(OE_B_RST);
        idle_check(20);
        // floating pins must read high and enable everything
        mode <= 3'h0;
        mode_float <= 3'h7;
        en_float <= 1'b1;
        enable_run();
        run_check(40, 1'b1, 3'h0);
        step();
        step();
        give_verdict();
    end
endmodule
